// ### rtl/control_mode_strap_decoder.sv
// Purpose: Resolve three-level straps into pin-controlled settings or a serial link
// Assumes: Strap comparator bits are synchronous to mclk
// Notes:   A comparator pair reading high-only is treated as floating
//
// Operation
// - Mode strap high or low gives pin-controlled mode, serial link idle.
// - Mode strap floating gives serial control; shared pins become the serial link.
// - In pin mode, mode strap low picks small range, high picks large range.
// - Swing strap must be high or low; low small swing, high large swing.
// - Edge strap low launches data on negative edge, high on positive edge.
// - Edge strap floating gives double-rate output clock; edge choice ignored.
// - Calibration strap low picks short wait, high picks long wait.
// - Calibration strap floating uses short wait and enables dual-edge sampling.
// - Serial mode: swing pin is clock, edge pin data, calibration pin select.
`timescale 1ns/1ps
module control_mode_strap_decoder (
	input  wire logic                          mclk,
	input  wire logic                          rst_n,
	input  wire strap_decode_pkg::strap_pins_t strapPins,
	output logic                               serialMode,
	output strap_decode_pkg::pin_settings_t    settings,
	output logic                               swingStrapFault,
	output logic                               serialLinkClock,
	output logic                               serial_link_data,
	output logic                               serial_link_select_n
);
	import strap_decode_pkg::*;

	// ------------------------------------------------------------------
	// Level resolution
	// ------------------------------------------------------------------
	function automatic strap_level_t resolveLevel(input strap_sense_t s);
		case ({s.aboveHigh, s.aboveLow})
			2'b00:   resolveLevel = STRAP_LOW;
			2'b11:   resolveLevel = STRAP_HIGH;
			default: resolveLevel = STRAP_FLOAT;
		endcase
	endfunction : resolveLevel

	strap_levels_t levels_reg;
	pin_settings_t settings_next;
	logic          serialMode_next;

	// First stage holds resolved levels; a pad in transit is not filtered and reaches the datapath an edge later
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			levels_reg <= LEVELS_RESET;
		end else begin
			levels_reg.modeSel  <= resolveLevel(strapPins.modeSel);
			levels_reg.swingSel <= resolveLevel(strapPins.swingSel);
			levels_reg.edgeSel  <= resolveLevel(strapPins.edgeSel);
			levels_reg.calSel   <= resolveLevel(strapPins.calSel);
		end
	end

	// ------------------------------------------------------------------
	// Setting decode
	// ------------------------------------------------------------------
	always_comb begin
		serialMode_next = (levels_reg.modeSel == STRAP_FLOAT);
		settings_next   = SETTINGS_RESET;
		if (!serialMode_next) begin
			settings_next.rangeLarge = (levels_reg.modeSel == STRAP_HIGH);
			settings_next.swingLarge = (levels_reg.swingSel == STRAP_HIGH);
			if (levels_reg.edgeSel == STRAP_FLOAT) begin
				settings_next.ddrClock = 1'b1;
			end else begin
				settings_next.output_launch_edge_select = (levels_reg.edgeSel == STRAP_HIGH);
			end
			if (levels_reg.calSel == STRAP_FLOAT) begin
				settings_next.dualEdgeSample = 1'b1;
			end else begin
				settings_next.calibration_wait_select = (levels_reg.calSel == STRAP_HIGH);
			end
		end
	end

	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			serialMode <= 1'b0;
			settings   <= SETTINGS_RESET;
		end else begin
			serialMode <= serialMode_next;
			settings   <= settings_next;
		end
	end

	// Floating swing strap has no defined meaning; flag it, small swing is used
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			swingStrapFault <= 1'b0;
		end else begin
			swingStrapFault <= !serialMode_next && (levels_reg.swingSel == STRAP_FLOAT);
		end
	end

	// ------------------------------------------------------------------
	// Serial link pins
	// ------------------------------------------------------------------
	// Outside serial mode the link is parked idle with select inactive
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			serialLinkClock      <= 1'b0;
			serial_link_data     <= 1'b0;
			serial_link_select_n <= SELECT_N_RESET;
		end else if (serialMode_next) begin
			serialLinkClock      <= (levels_reg.swingSel == STRAP_HIGH);
			serial_link_data     <= (levels_reg.edgeSel == STRAP_HIGH);
			serial_link_select_n <= (levels_reg.calSel == STRAP_HIGH);
		end else begin
			serialLinkClock      <= 1'b0;
			serial_link_data     <= 1'b0;
			serial_link_select_n <= SELECT_N_RESET;
		end
	end

	// ------------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------------
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rst_n);

	// Split comparator codes, 01 and 10 alike, mean an open mode pad
	sequence modeFloatIn;
		strapPins.modeSel.aboveHigh != strapPins.modeSel.aboveLow;
	endsequence

	sequence pinModeIn;
		strapPins.modeSel.aboveHigh == strapPins.modeSel.aboveLow;
	endsequence

	sequence swingOpenIn;
		strapPins.modeSel.aboveHigh == strapPins.modeSel.aboveLow && strapPins.swingSel == 2'b01;
	endsequence

	sequence hostSelects;
		strapPins.modeSel == 2'b01 && strapPins.calSel == 2'b00;
	endsequence

	AST_PIN_MODE_LINK_IDLE: assert property (
		pinModeIn ##1 rst_n ##1 1'b1 |-> !serialMode && serial_link_select_n && !serialLinkClock)
		else $error("Serial link active in pin-controlled mode");

	AST_FLOAT_SERIAL: assert property (
		modeFloatIn ##1 rst_n ##1 1'b1 |-> serialMode && settings == SETTINGS_RESET)
		else $error("Floating mode strap did not select serial control");

	AST_RANGE: assert property (
		!serialMode |-> settings.rangeLarge == ($past(levels_reg.modeSel) == STRAP_HIGH))
		else $error("Input range does not follow mode strap");

	AST_SWING: assert property (
		!serialMode |-> settings.swingLarge == ($past(levels_reg.swingSel) == STRAP_HIGH)
		&& swingStrapFault == ($past(levels_reg.swingSel) == STRAP_FLOAT))
		else $error("Swing setting or fault wrong");

	AST_EDGE: assert property (
		!serialMode && !settings.ddrClock |->
		settings.output_launch_edge_select == ($past(levels_reg.edgeSel) == STRAP_HIGH))
		else $error("Launch edge does not follow edge strap");

	AST_DDR: assert property (
		!serialMode |-> settings.ddrClock == ($past(levels_reg.edgeSel) == STRAP_FLOAT)
		&& !(settings.ddrClock && settings.output_launch_edge_select))
		else $error("Double-rate clock choice wrong");

	AST_CAL: assert property (
		!serialMode && !settings.dualEdgeSample |->
		settings.calibration_wait_select == ($past(levels_reg.calSel) == STRAP_HIGH))
		else $error("Calibration wait does not follow strap");

	AST_DES: assert property (
		!serialMode |-> settings.dualEdgeSample == ($past(levels_reg.calSel) == STRAP_FLOAT)
		&& !(settings.dualEdgeSample && settings.calibration_wait_select))
		else $error("Dual-edge sampling choice wrong");

	AST_SERIAL_PINS: assert property (
		modeFloatIn ##1 rst_n ##1 rst_n |->
		serialLinkClock == $past(strapPins.swingSel == 2'b11, 2)
		&& serial_link_data == $past(strapPins.edgeSel == 2'b11, 2)
		&& serial_link_select_n == $past(strapPins.calSel == 2'b11, 2))
		else $error("Serial pins not routed");

	AST_LATENCY: assert property (
		$rose(serialMode) |-> $past(strapPins.modeSel.aboveHigh != strapPins.modeSel.aboveLow, 2))
		else $error("Mode change without floating strap two cycles earlier");

	AST_SWING_OPEN: assert property (
		swingOpenIn ##1 rst_n ##1 rst_n |-> swingStrapFault && !settings.swingLarge)
		else $error("Open swing strap not flagged");

	AST_HOST_SELECT: assert property (
		hostSelects ##1 rst_n ##1 rst_n |-> serialMode && !serial_link_select_n)
		else $error("Host chip select not passed through");

	AST_SERIAL_SETTINGS: assert property (
		serialMode |-> settings == SETTINGS_RESET && !swingStrapFault)
		else $error("Pin settings applied in serial control mode");

	AST_PIN_LINK_PARKED: assert property (
		!serialMode |-> !serialLinkClock && !serial_link_data && serial_link_select_n)
		else $error("Serial link not parked in pin-controlled mode");

	AST_MODE_FOLLOWS: assert property (
		serialMode == ($past(levels_reg.modeSel) == STRAP_FLOAT))
		else $error("Control mode does not follow resolved mode strap");

	// The first stage must map every comparator code; skipped on the edge after reset
	AST_RESOLVE_LOW: assert property (
		$past(rst_n) && $past(strapPins.edgeSel) == 2'b00 |-> levels_reg.edgeSel == STRAP_LOW)
		else $error("Low comparator code not resolved as low");

	AST_RESOLVE_HIGH: assert property (
		$past(rst_n) && $past(strapPins.edgeSel) == 2'b11 |-> levels_reg.edgeSel == STRAP_HIGH)
		else $error("High comparator code not resolved as high");

	AST_RESOLVE_FLOAT: assert property (
		$past(rst_n) && $past(strapPins.modeSel) == 2'b01 |-> levels_reg.modeSel == STRAP_FLOAT)
		else $error("Open comparator code not resolved as floating");

	AST_RESOLVE_ODD: assert property (
		$past(rst_n) && $past(strapPins.calSel) == 2'b10 |-> levels_reg.calSel == STRAP_FLOAT)
		else $error("High-only comparator code not resolved as floating");

endmodule : control_mode_strap_decoder

// ### rtl/strap_decode_pkg.sv
// Purpose: Shared types and constants for the control mode strap decoder
// Assumes: Each strap reaches the logic as two threshold comparator bits
// Notes:   Latency from strap pins to decoded outputs is two clock edges
package strap_decode_pkg;

	// ------------------------------------------------------------------
	// Strap levels
	// ------------------------------------------------------------------
	typedef enum logic [1:0] {
		STRAP_LOW   = 2'b00,
		STRAP_FLOAT = 2'b01,
		STRAP_HIGH  = 2'b11
	} strap_level_t;

	// Comparator pair from one pad: above the low and above the high threshold
	typedef struct packed {
		logic aboveHigh;
		logic aboveLow;
	} strap_sense_t;

	// The four strap pads
	typedef struct packed {
		strap_sense_t modeSel;
		strap_sense_t swingSel;
		strap_sense_t edgeSel;
		strap_sense_t calSel;
	} strap_pins_t;

	// Resolved levels, one per pad
	typedef struct packed {
		strap_level_t modeSel;
		strap_level_t swingSel;
		strap_level_t edgeSel;
		strap_level_t calSel;
	} strap_levels_t;

	// Settings applied to the datapath in pin-controlled mode
	typedef struct packed {
		logic rangeLarge;
		logic swingLarge;
		logic output_launch_edge_select;
		logic ddrClock;
		logic calibration_wait_select;
		logic dualEdgeSample;
	} pin_settings_t;

	// ------------------------------------------------------------------
	// Reset values and timing
	// ------------------------------------------------------------------
	localparam strap_levels_t LEVELS_RESET   = '{STRAP_LOW, STRAP_LOW, STRAP_LOW, STRAP_LOW};
	localparam pin_settings_t SETTINGS_RESET = 6'h00;
	localparam logic          SELECT_N_RESET = 1'b1;
	localparam int            DECODE_LATENCY = 2;

endpackage : strap_decode_pkg

// ### tb/strap_wiring_model.sv
// Purpose: Board strap wiring as the pad comparator pairs see it
// Assumes: An open pad settles between the low and high thresholds
// Notes:   oddFloat shows an open pad as the high-only code instead
`timescale 1ns/1ps
module strap_wiring_model (
	input  wire strap_decode_pkg::strap_levels_t levels,
	input  wire logic                            oddFloat,
	output strap_decode_pkg::strap_pins_t        strapPins
);
	import strap_decode_pkg::*;

	function automatic strap_sense_t sense(input strap_level_t lv, input logic odd);
		if (lv == STRAP_FLOAT)
			return odd ? 2'h2 : 2'h1;
		return (lv == STRAP_HIGH) ? 2'h3 : 2'h0;
	endfunction : sense

	// Serial mode reuses the same pads, so the link bits arrive as plain levels
	assign strapPins = '{sense(levels.modeSel, oddFloat), sense(levels.swingSel, oddFloat),
		sense(levels.edgeSel, oddFloat), sense(levels.calSel, oddFloat)};
endmodule : strap_wiring_model

// ### tb/testbench.sv
// Purpose: Self-checking bench for the control mode strap decoder
// Assumes: Decode latency of two edges, straps driven by NBA at posedge
// Notes:   Table rows cover ordinary straps; reset and odd codes follow
`timescale 1ns/1ps
module testbench;
	import strap_decode_pkg::*;
	localparam strap_level_t L = STRAP_LOW, H = STRAP_HIGH, F = STRAP_FLOAT;
	typedef struct packed {
		strap_levels_t lv;
		pin_settings_t set;
		logic [4:0]    misc;
	} row_t;
	// misc holds serialMode, fault, link clock, link data, select_n
	localparam row_t ROWS [8] = '{'{'{L,L,L,L}, 6'h00, 5'h01}, '{'{H,H,H,H}, 6'h3a, 5'h01},
		'{'{H,L,F,L}, 6'h24, 5'h01}, '{'{L,H,L,F}, 6'h11, 5'h01}, '{'{L,F,H,H}, 6'h0a, 5'h09},
		'{'{F,H,L,H}, 6'h00, 5'h15}, '{'{F,L,H,L}, 6'h00, 5'h12}, '{'{F,H,H,L}, 6'h00, 5'h16}};
	logic          mclk, rst_n, oddFloat, serialMode, swingStrapFault;
	logic          serialLinkClock, serial_link_data, serial_link_select_n;
	strap_levels_t levels;
	strap_pins_t   strapPins;
	pin_settings_t settings;
	int            bad_count = 0, num_checks = 0;
	wire [4:0]     misc = {serialMode, swingStrapFault, serialLinkClock, serial_link_data,
		serial_link_select_n};

	strap_wiring_model u_wiring (.levels(levels), .oddFloat(oddFloat), .strapPins(strapPins));
	control_mode_strap_decoder u_dut (.mclk(mclk), .rst_n(rst_n), .strapPins(strapPins),
		.serialMode(serialMode), .settings(settings), .swingStrapFault(swingStrapFault),
		.serialLinkClock(serialLinkClock), .serial_link_data(serial_link_data),
		.serial_link_select_n(serial_link_select_n));

	initial begin
		mclk = 1'b0;
		forever #5 mclk = ~mclk;
	end

	task automatic check_set(input pin_settings_t exp);
		num_checks++;
		if (settings !== exp) begin
			bad_count++;
			$display("Error t=%0t settings got %h exp %h", $time, settings, exp);
		end
	endtask : check_set

	task automatic check_misc(input logic [4:0] exp);
		num_checks++;
		if (misc !== exp) begin
			bad_count++;
			$display("Error t=%0t status got %h exp %h", $time, misc, exp);
		end
	endtask : check_misc

	// Hold a row two edges past the launch edge, then look
	task automatic apply(input row_t r);
		@(posedge mclk);
		levels <= r.lv;
		repeat (DECODE_LATENCY) @(posedge mclk);
		#1;
		check_set(r.set);
		check_misc(r.misc);
	endtask : apply

	task automatic wrap_up;
		$display("checks %0d mismatches %0d", num_checks, bad_count);
		if (bad_count == 0 && num_checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : wrap_up

	initial begin
		#100000;
		bad_count++;
		wrap_up();
	end

	initial begin
		rst_n = 1'b0;
		oddFloat = 1'b0;
		levels = ROWS[1].lv;
		repeat (2) @(posedge mclk);
		#1;
		check_set(SETTINGS_RESET);
		check_misc(5'h01);
		@(posedge mclk);
		rst_n <= 1'b1;
		$display("test reset done");
		foreach (ROWS[i])
			apply(ROWS[i]);
		$display("test table done");
		// Back to back change: old value must stand one edge longer
		@(posedge mclk);
		levels <= ROWS[1].lv;
		@(posedge mclk);
		#1;
		check_set(ROWS[7].set);
		check_misc(ROWS[7].misc);
		@(posedge mclk);
		#1;
		check_set(ROWS[1].set);
		check_misc(ROWS[1].misc);
		$display("test latency done");
		// Comparator code 10 must still read as an open pad
		@(posedge mclk);
		oddFloat <= 1'b1;
		apply(ROWS[2]);
		apply(ROWS[3]);
		apply(ROWS[5]);
		@(posedge mclk);
		oddFloat <= 1'b0;
		$display("test odd code done");
		// Reset in mid-run from serial mode
		@(posedge mclk);
		rst_n <= 1'b0;
		repeat (2) @(posedge mclk);
		#1;
		check_set(SETTINGS_RESET);
		check_misc(5'h01);
		@(posedge mclk);
		rst_n <= 1'b1;
		apply(ROWS[6]);
		$display("test mid reset done");
		wrap_up();
	end
endmodule : testbench
